// ### bench/aout_model.sv
// Purpose: Analog output module seen by the latch
// Assumes: Takes the word on the strobe edge
// Notes: Keeps only the latest channel write
`timescale 1ns/10ps
`default_nettype none
module aout_model
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // From the latch
  input wire logic aout_strobe,
  input wire logic [latch_pkg::CHAN_W-1:0] aout_chan,
  input wire logic [latch_pkg::WORD_W-1:0] aout_word,
  // Last write
  output logic [latch_pkg::CHAN_W-1:0] last_chan,
  output logic [latch_pkg::WORD_W-1:0] last_word
);
  import latch_pkg::*;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      last_chan <= CHAN_RESET;
      last_word <= WORD_RESET;
    end
    else if (aout_strobe)
    begin
      last_chan <= aout_chan;
      last_word <= aout_word;
    end
  end
endmodule
`default_nettype wire

// ### bench/latch_checker.sv
// Purpose: Port-level checks for the falling-edge analog latch
// Assumes: clk_en held high; pins reach the core through two flops
// Notes: Pin history is three to four cycles deep
`timescale 1ns/10ps
`default_nettype none
module latch_checker
(
  // Clock and pins
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable_pin,
  input wire logic trigger_pin,
  input wire logic [latch_pkg::WORD_W-1:0] analog_pin,
  input wire logic analog_signed_pin,
  input wire logic nest_first,
  input wire logic nest_second,
  // Outputs
  input wire logic [latch_pkg::WORD_W-1:0] aout_word,
  input wire logic aout_signed,
  input wire logic aout_strobe,
  input wire logic nest_strobe,
  input wire logic [latch_pkg::WORD_W-1:0] latched_word,
  input wire logic block_active,
  input wire logic [latch_pkg::COUNT_W-1:0] capture_count
);
  import latch_pkg::*;
  logic cap;
  assign cap = aout_strobe || nest_strobe;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence pin_fall;
    $past(trigger_pin, 4) && !$past(trigger_pin, 3);
  endsequence
  sequence plain_run;
    block_active && $past(block_active) && !nest_first && !nest_second;
  endsequence
  // Enabling seen at the output with the synced trigger already low
  sequence low_enable;
    $rose(block_active) && !nest_first && !nest_second && !$past(trigger_pin, 3);
  endsequence
  fall_capture_a: assert property (plain_run ##0 pin_fall |-> aout_strobe)
    else $error("no capture on trigger fall");
  word_copy_a: assert property (aout_strobe |-> aout_word == $past(analog_pin, 3))
    else $error("captured word differs from input");
  type_follow_a: assert property (aout_strobe |-> aout_signed == $past(analog_signed_pin, 3))
    else $error("output type differs from input");
  word_hold_a: assert property (!cap |-> $stable(latched_word))
    else $error("latched word moved without capture");
  frozen_off_a: assert property (cap |-> block_active)
    else $error("capture while disabled");
  enable_track_a: assert property (block_active == $past(enable_pin, 3))
    else $error("run state does not follow enable");
  low_enable_a: assert property (low_enable |-> aout_strobe)
    else $error("no capture when enabled with trigger low");
  high_enable_a: assert property ($rose(block_active) && !nest_second && $past(trigger_pin, 3) |-> !cap)
    else $error("capture when enabled with trigger high");
  route_a: assert property (nest_first ? !aout_strobe : !nest_strobe)
    else $error("capture sent to wrong destination");
  count_step_a: assert property (cap |-> capture_count == $past(capture_count) + COUNT_STEP)
    else $error("capture count did not step");
endmodule
bind falling_edge_analog_latch latch_checker chk (.ref_clk, .rst, .enable_pin, .trigger_pin, .analog_pin,
  .analog_signed_pin, .nest_first, .nest_second, .aout_word, .aout_signed, .aout_strobe, .nest_strobe,
  .latched_word, .block_active, .capture_count);
`default_nettype wire

// ### bench/tb.sv
// Purpose: Self-checking bench for the falling-edge analog latch
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Results are matched in order through a queue
`timescale 1ns/10ps
`default_nettype none
module tb;
  import latch_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic enable_pin = 1'b0, trigger_pin = 1'b1, analog_signed_pin = 1'b0;
  logic nest_first = 1'b0, nest_second = 1'b0, nest_trig_in = 1'b1;
  logic [WORD_W-1:0] analog_pin = 16'h0000;
  logic [CHAN_W-1:0] chan_select = 2'h0;
  logic [WORD_W-1:0] aout_word, nest_word, latched_word, last_word;
  logic [CHAN_W-1:0] aout_chan, last_chan;
  logic aout_signed, aout_strobe, nest_signed, nest_strobe, latched_signed, block_active;
  logic [COUNT_W-1:0] capture_count;
  logic [19:0] exp_q[$];
  logic [19:0] got;
  logic [19:0] exp_e;
  logic [19:0] exp_aout = 20'h00000;
  logic [31:0] rng = 32'h00006BB2;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  always #2.5 ref_clk = ~ref_clk;
  falling_edge_analog_latch uut (.ref_clk, .rst, .clk_en, .enable_pin, .trigger_pin, .analog_pin,
    .analog_signed_pin, .nest_first, .nest_second, .nest_trig_in, .chan_select, .aout_word, .aout_signed,
    .aout_chan, .aout_strobe, .nest_word, .nest_signed, .nest_strobe, .latched_word, .latched_signed,
    .block_active, .capture_count);
  aout_model far (.ref_clk, .rst, .aout_strobe, .aout_chan, .aout_word, .last_chan, .last_word);
  function automatic logic [31:0] nxt(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic compare(input logic [19:0] e, input logic [19:0] g);
    checked++;
    if (e !== g)
    begin
      n_mismatch++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic final_report;
    $display("checked=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Word settles well before the fall, since nested falls bypass the sync flops
  task automatic fall(input logic keep);
    rng = nxt(rng);
    analog_pin = rng[15:0];
    analog_signed_pin = rng[16];
    chan_select = rng[18:17];
    step(4);
    if (keep)
      exp_q.push_back({nest_first ? 2'h0 : chan_select, nest_first, analog_signed_pin, analog_pin});
    if (keep && !nest_first)
      exp_aout = {chan_select, 2'h0, analog_pin};
    if (nest_second)
      nest_trig_in = 1'b0;
    else
      trigger_pin = 1'b0;
    step(5);
    nest_trig_in = 1'b1;
    trigger_pin = 1'b1;
    step(5);
  endtask
  always @(negedge ref_clk)
  begin
    if (aout_strobe === 1'b1 || nest_strobe === 1'b1)
    begin
      exp_e = exp_q.size() > 0 ? exp_q.pop_front() : 20'hFFFFF;
      // Destination word and type come from whichever side was strobed
      if (nest_strobe === 1'b1)
        got = {2'h0, 1'b1, nest_signed, nest_word};
      else
        got = {aout_chan, 1'b0, aout_signed, aout_word};
      compare(exp_e, got);
      compare({3'h0, exp_e[16:0]}, {3'h0, latched_signed, latched_word});
    end
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  initial
  begin
    step(6);
    rst = 1'b0;
    step(2);
    enable_pin = 1'b1;
    step(6);
    compare(20'h00001, {19'h00000, block_active});
    $display("test enable done");
    repeat (4) fall(1'b1);
    $display("test falls done");
    enable_pin = 1'b0;
    step(5);
    compare(20'h00000, {19'h00000, block_active});
    fall(1'b0);
    compare(exp_aout, {aout_chan, 2'h0, aout_word});
    trigger_pin = 1'b0;
    rng = nxt(rng);
    analog_pin = rng[15:0];
    step(5);
    exp_q.push_back({chan_select, 1'b0, analog_signed_pin, analog_pin});
    enable_pin = 1'b1;
    step(6);
    trigger_pin = 1'b1;
    step(5);
    $display("test disable done");
    nest_first = 1'b1;
    fall(1'b1);
    nest_first = 1'b0;
    nest_second = 1'b1;
    fall(1'b1);
    nest_second = 1'b0;
    fall(1'b1);
    compare(exp_aout, {last_chan, 2'h0, last_word});
    compare(20'h00000, 20'(exp_q.size()));
    $display("test nesting done");
    final_report();
  end
endmodule
`default_nettype wire

// ### core/falling_edge_analog_latch.sv
// Purpose: Falling-edge analog latch: captures a 16-bit word when the trigger drops from 1 to 0.
// Assumes: One update cycle per ref_clk edge with clk_en high; config inputs are quasi-static.
// Notes: Pins pass two flip-flops; the nested trigger comes from same-clock logic and does not.
`timescale 1ns/10ps
`default_nettype none

// Operation
// [RQ1] While enabled, a 1-to-0 trigger change captures the analog input word onto the output.
// [RQ2] The captured word holds through the low phase and the return high, changing only on the next fall.
// [RQ3] The output is a 16-bit word equal to the input at the latest falling trigger edge.
// [RQ4] The input source supplies 0 to 65535 unsigned or -32768 to +32767 signed.
// [RQ5] The 16 bits are copied unaltered with no signed or unsigned interpretation.
// [RQ6] The output carries the same value type (signed or unsigned) as the captured input.
// [RQ7] Enable high (or tied high) means enabled, enable low (or tied low) means disabled.
// [RQ8] While disabled nothing is captured and the output stays frozen at its last value.
// [RQ9] While disabled the trigger and analog inputs are still sampled but not acted on.
// [RQ10] On enabling the block acts at once on the most recent sampled inputs.
// [RQ11] A trigger already low at enabling counts as a falling edge and captures at once.
// [RQ12] A trigger high at enabling waits for the next high-to-low change before any capture.
// [RQ13] The trigger source should hold the trigger high at start-up.
// [RQ14] As second block of a nested pair the first block's output serves as the trigger.
// [RQ15] As first block of a nested pair the output goes to the second block, not to a channel.
// [RQ16] When not first of a pair the captured word goes to one selected analog output channel.
// [RQ17] Edges are found by comparing each update's trigger with the one registered the update before.
module falling_edge_analog_latch
  import latch_pkg::*;
#(
  parameter int unsigned CHAN_SEL_W = latch_pkg::CHAN_W
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Block input pins
  input wire logic enable_pin,
  input wire logic trigger_pin,
  input wire logic [latch_pkg::WORD_W-1:0] analog_pin,
  input wire logic analog_signed_pin,
  // Nesting configuration
  input wire logic nest_first,
  input wire logic nest_second,
  input wire logic nest_trig_in,
  // Output channel choice
  input wire logic [CHAN_SEL_W-1:0] chan_select,
  // Towards the analog output module
  output logic [latch_pkg::WORD_W-1:0] aout_word,
  output logic aout_signed,
  output logic [CHAN_SEL_W-1:0] aout_chan,
  output logic aout_strobe,
  // Towards the nested second block
  output logic [latch_pkg::WORD_W-1:0] nest_word,
  output logic nest_signed,
  output logic nest_strobe,
  // Status
  output logic [latch_pkg::WORD_W-1:0] latched_word,
  output logic latched_signed,
  output logic block_active,
  output logic [latch_pkg::COUNT_W-1:0] capture_count
);
  import latch_pkg::*;

  typedef struct packed
  {
    mode_e mode;
    logic trig_prev;
    logic [WORD_W-1:0] latched;
    logic latched_sgn;
    logic [WORD_W-1:0] aout_word;
    logic aout_sgn;
    logic [CHAN_SEL_W-1:0] aout_chan;
    logic aout_stb;
    logic [WORD_W-1:0] nest_word;
    logic nest_sgn;
    logic nest_stb;
    logic active;
    logic [COUNT_W-1:0] count;
  } latch_s;

  localparam latch_s LATCH_RESET = '{
    mode: MODE_OFF,
    trig_prev: TRIG_IDLE,
    latched: WORD_RESET,
    latched_sgn: SIGNED_RESET,
    aout_word: WORD_RESET,
    aout_sgn: SIGNED_RESET,
    aout_chan: CHAN_SEL_W'(CHAN_RESET),
    aout_stb: 1'b0,
    nest_word: WORD_RESET,
    nest_sgn: SIGNED_RESET,
    nest_stb: 1'b0,
    active: 1'b0,
    count: COUNT_RESET
  };

  sample_if smp ();

  latch_s st_reg;
  latch_s st_next;

  input_sampler u_sampler
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .enable_pin(enable_pin),
    .trigger_pin(trigger_pin),
    .analog_pin(analog_pin),
    .analog_signed_pin(analog_signed_pin),
    .smp(smp.src)
  );

  always_comb
  begin
    logic trig_now;
    logic fell;
    logic capture;
    trig_now = 1'b1;
    fell = 1'b0;
    capture = 1'b0;
    st_next = st_reg;
    st_next.aout_stb = 1'b0;
    st_next.nest_stb = 1'b0;

    // Second of a pair takes its trigger from the first block
    trig_now = nest_second ? nest_trig_in : smp.trig; // RQ14
    fell = st_reg.trig_prev & ~trig_now; // RQ17

    case (st_reg.mode)
      MODE_OFF:
      begin
        // Trigger low on enabling acts as a fresh fall
        if (smp.en) // RQ7
        begin
          st_next.mode = MODE_RUN; // RQ10
          capture = ~trig_now; // RQ11 RQ12
        end
      end
      MODE_RUN:
      begin
        if (!smp.en) // RQ7
        begin
          st_next.mode = MODE_OFF; // RQ8
        end
        else
        begin
          capture = fell; // RQ1 RQ2
        end
      end
      default:
      begin
        st_next.mode = MODE_OFF;
      end
    endcase

    // History keeps moving while disabled so enabling sees current inputs
    st_next.trig_prev = trig_now; // RQ9 RQ17
    st_next.active = (st_next.mode == MODE_RUN);

    if (capture)
    begin
      // Plain bit copy; the type flag rides alongside
      st_next.latched = smp.word; // RQ3 RQ5
      st_next.latched_sgn = smp.word_signed; // RQ6
      st_next.count = st_reg.count + COUNT_STEP;
      if (nest_first)
      begin
        st_next.nest_word = smp.word; // RQ15
        st_next.nest_sgn = smp.word_signed; // RQ6
        st_next.nest_stb = 1'b1;
      end
      else
      begin
        st_next.aout_word = smp.word; // RQ16
        st_next.aout_sgn = smp.word_signed; // RQ6
        st_next.aout_chan = chan_select; // RQ16
        st_next.aout_stb = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= LATCH_RESET;
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
    end
  end

  // All outputs straight from the state register
  assign aout_word = st_reg.aout_word;
  assign aout_signed = st_reg.aout_sgn;
  assign aout_chan = st_reg.aout_chan;
  assign aout_strobe = st_reg.aout_stb;
  assign nest_word = st_reg.nest_word;
  assign nest_signed = st_reg.nest_sgn;
  assign nest_strobe = st_reg.nest_stb;
  assign latched_word = st_reg.latched;
  assign latched_signed = st_reg.latched_sgn;
  assign block_active = st_reg.active;
  assign capture_count = st_reg.count;

endmodule

`default_nettype wire

// ### core/input_sampler.sv
// Purpose: Two-stage synchroniser for the enable, trigger and analog input pins.
// Assumes: Pins are asynchronous to ref_clk; the analog word is held steady by its source.
// Notes: Keeps sampling whatever the enable says.
`timescale 1ns/10ps
`default_nettype none

module input_sampler
  import latch_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Raw pins
  input wire logic enable_pin,
  input wire logic trigger_pin,
  input wire logic [latch_pkg::WORD_W-1:0] analog_pin,
  input wire logic analog_signed_pin,
  // Synchronised view
  sample_if.src smp
);
  import latch_pkg::*;

  typedef struct packed
  {
    logic en;
    logic trig;
    logic [WORD_W-1:0] word;
    logic word_signed;
  } stage_s;

  typedef struct packed
  {
    stage_s first;
    stage_s second;
  } sampler_s;

  localparam stage_s STAGE_RESET = '{en: 1'b0, trig: TRIG_IDLE, word: WORD_RESET, word_signed: SIGNED_RESET};

  sampler_s st_reg;
  sampler_s st_next;

  // First stage feeds only the second stage
  always_comb
  begin
    st_next = st_reg;
    st_next.first.en = enable_pin;
    st_next.first.trig = trigger_pin;
    st_next.first.word = analog_pin;
    st_next.first.word_signed = analog_signed_pin;
    st_next.second = st_reg.first;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '{first: STAGE_RESET, second: STAGE_RESET};
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
    end
  end

  assign smp.en = st_reg.second.en;
  assign smp.trig = st_reg.second.trig;
  assign smp.word = st_reg.second.word;
  assign smp.word_signed = st_reg.second.word_signed;

endmodule

`default_nettype wire

// ### shared/latch_pkg.sv
// Purpose: Shared constants and types for the falling-edge analog latch.
// Assumes: One 200 MHz clock; every update cycle is one ref_clk edge with clk_en high.
// Notes: Widths here are fixed for all modules except the core's channel width, which is its CHAN_SEL_W parameter.
`default_nettype none

package latch_pkg;

  // Clock
  localparam int unsigned CLK_PERIOD_PS = 5000;

  // Data path widths
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CHAN_COUNT = 4;
  localparam int unsigned CHAN_W = 2;
  localparam int unsigned COUNT_W = 16;

  // Input synchroniser depth for pins
  localparam int unsigned SYNC_STAGES = 2;

  // Reset values and the capture count step
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 2'h0;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_STEP = 16'h0001;
  localparam logic TRIG_IDLE = 1'b1;
  localparam logic SIGNED_RESET = 1'b0;

  // Block operating mode
  typedef enum logic [0:0]
  {
    MODE_OFF,
    MODE_RUN
  } mode_e;

endpackage

`default_nettype wire

// ### shared/sample_if.sv
// Purpose: Carries the synchronised block inputs from the sampler to the latch core.
// Assumes: Both ends run on ref_clk.
// Notes: Values here are already past two flip-flops.
`timescale 1ns/10ps
`default_nettype none

interface sample_if;
  import latch_pkg::*;

  logic en;
  logic trig;
  logic [WORD_W-1:0] word;
  logic word_signed;

  modport src
  (
    output en,
    output trig,
    output word,
    output word_signed
  );

  modport dst
  (
    input en,
    input trig,
    input word,
    input word_signed
  );

endinterface

`default_nettype wire
